// >>> core/prc_pkg.sv
// package for the reset and suspend control block
package prc_pkg;
  localparam int PRC_NUM_OUT = 8;
  localparam int PRC_CFG_W = 8;
  localparam int PRC_STICKY_W = 8;
  localparam logic [PRC_CFG_W-1:0] PRC_CFG_RST = 8'h00;
  localparam logic [PRC_STICKY_W-1:0] PRC_STICKY_RST = 8'h00;
  localparam logic [PRC_NUM_OUT-1:0] PRC_OUT_RST = 8'h00;
  // positions of the platform pins inside the synchroniser word
  localparam int PRC_SYNC_W = 3;
  localparam int PRC_SYNC_GLOBAL_RESET_IN = 0;
  localparam int PRC_SYNC_PCI_BUS_RESET_IN = 1;
  localparam int PRC_SYNC_SUSP = 2;

  typedef enum logic [2:0] {
    PRC_ST_GLOBAL = 3'b001,
    PRC_ST_BUSRST = 3'b010,
    PRC_ST_RUN    = 3'b100
  } prc_state_e;

  // outputs with their enables travel together
  typedef struct packed {
    logic [PRC_NUM_OUT-1:0] data;
    logic [PRC_NUM_OUT-1:0] oe;
  } prc_pins_s;

  // register write request from the function logic
  typedef struct packed {
    logic cfg_we;
    logic [PRC_CFG_W-1:0] cfg_wdata;
    logic sticky_we;
    logic [PRC_STICKY_W-1:0] sticky_wdata;
  } prc_wr_s;
endpackage : prc_pkg

// >>> core/prc_reset_ctrl.sv
// reset and suspend control for the card controller core
// Function
// - global reset floats every output and returns all registers to reset values.
// - while global reset is held the block sits fully in its default state.
// - with suspend enabled global reset floats outputs but keeps all registers.
// - bus reset floats all outputs and clears only the bus-reset register subset.
// - nothing functions while bus reset is held.
// - on bus reset release the block comes up in its default operating state.
// - suspend with bus reset keeps all register contents and floats outputs.
`timescale 1ns/1ps
module prc_reset_ctrl
  import prc_pkg::*;
(
  // clock and reset
  input wire logic CLK,
  input wire logic RST,
  // platform reset pins, asynchronous
  input wire logic GLOBAL_RESET_IN,
  input wire logic PCI_BUS_RESET_IN,
  input wire logic SUSPEND_IN,
  // function side
  input wire prc_pkg::prc_wr_s WR,
  input wire logic [PRC_NUM_OUT-1:0] FUNC_OUT,
  input wire logic [PRC_NUM_OUT-1:0] FUNC_OE,
  // status and pins
  output logic FUNC_ENABLE,
  output logic [PRC_CFG_W-1:0] CFG_Q,
  output logic [PRC_STICKY_W-1:0] STICKY_Q,
  output prc_pkg::prc_pins_s PINS
);
  import prc_pkg::*;

  // limitation: the pins reach the logic two edges after they move, so a reset
  // pulse shorter than one clock period may be missed entirely

  // synchroniser stages for the three platform pins
  logic [PRC_SYNC_W-1:0] sync1_ff;
  logic [PRC_SYNC_W-1:0] nxt_sync1;
  logic [PRC_SYNC_W-1:0] sync2_ff;
  logic [PRC_SYNC_W-1:0] nxt_sync2;

  // qualified reset and suspend levels
  logic global_reset_in;
  logic pci_bus_reset_in;
  logic susp;
  logic any_rst;

  // control state
  prc_state_e state_ff;
  prc_state_e nxt_state;
  // write gate, high only when a write may land
  logic run_ok;

  // register contents and their update requests
  logic [PRC_CFG_W-1:0] cfg_ff;
  logic [PRC_CFG_W-1:0] nxt_cfg;
  logic [PRC_STICKY_W-1:0] sticky_ff;
  logic [PRC_STICKY_W-1:0] nxt_sticky;
  logic cfg_clr;
  logic sticky_clr;
  logic cfg_wr;
  logic sticky_wr;

  // pin drivers
  prc_pins_s pins_ff;
  prc_pins_s nxt_pins;
  logic pin_drive;

  // sample on edge
  // the pins are asynchronous to CLK, so two stages guard against metastability
  always_comb begin
    nxt_sync1 = '0;
    nxt_sync1[PRC_SYNC_GLOBAL_RESET_IN] = GLOBAL_RESET_IN;
    nxt_sync1[PRC_SYNC_PCI_BUS_RESET_IN] = PCI_BUS_RESET_IN;
    nxt_sync1[PRC_SYNC_SUSP] = SUSPEND_IN;
    nxt_sync2 = sync1_ff;
  end

  always_ff @(posedge CLK) begin
    sync1_ff <= nxt_sync1;
    sync2_ff <= nxt_sync2;
  end

  assign global_reset_in = sync2_ff[PRC_SYNC_GLOBAL_RESET_IN] | RST;
  assign pci_bus_reset_in = sync2_ff[PRC_SYNC_PCI_BUS_RESET_IN];
  // RST is the power-on reset and is never shielded by suspend
  assign susp = sync2_ff[PRC_SYNC_SUSP] & ~RST;
  assign any_rst = global_reset_in | pci_bus_reset_in;

  // default on release
  // global reset outranks bus reset when both are held
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      PRC_ST_GLOBAL: begin
        // leave only once the global reset has fallen
        nxt_state = PRC_ST_GLOBAL;
        if (!global_reset_in && pci_bus_reset_in) begin
          nxt_state = PRC_ST_BUSRST;
        end else if (!global_reset_in) begin
          nxt_state = PRC_ST_RUN;
        end
      end
      PRC_ST_BUSRST: begin
        // global reset may still arrive on top of a bus reset
        nxt_state = PRC_ST_BUSRST;
        if (global_reset_in) begin
          nxt_state = PRC_ST_GLOBAL;
        end else if (!pci_bus_reset_in) begin
          nxt_state = PRC_ST_RUN;
        end
      end
      PRC_ST_RUN: begin
        nxt_state = PRC_ST_RUN;
        if (global_reset_in) begin
          nxt_state = PRC_ST_GLOBAL;
        end else if (pci_bus_reset_in) begin
          nxt_state = PRC_ST_BUSRST;
        end
      end
      default: begin
        // an unknown or illegal code falls back to the safe state
        nxt_state = PRC_ST_GLOBAL;
      end
    endcase
  end

  always_ff @(posedge CLK) begin
    state_ff <= nxt_state;
  end

  // writes refused
  // a reset already through the synchroniser blocks a write before the state shows it
  always_comb begin
    run_ok = 1'h0;
    case (state_ff)
      PRC_ST_RUN: begin
        run_ok = ~any_rst;
      end
      PRC_ST_GLOBAL: begin
        run_ok = 1'h0;
      end
      PRC_ST_BUSRST: begin
        run_ok = 1'h0;
      end
      default: begin
        run_ok = 1'h0;
      end
    endcase
  end

  assign cfg_wr = run_ok & WR.cfg_we;
  assign sticky_wr = run_ok & WR.sticky_we;

  // suspend keeps contents
  // sticky stands for event context, so only a global reset may clear it
  always_comb begin
    cfg_clr = 1'h0;
    sticky_clr = 1'h0;
    if (global_reset_in) begin
      cfg_clr = ~susp;
      sticky_clr = ~susp;
    end else if (pci_bus_reset_in) begin
      cfg_clr = ~susp;
    end
  end

  // a clear outranks a write landing in the same cycle
  always_comb begin
    nxt_cfg = cfg_ff;
    nxt_sticky = sticky_ff;
    if (cfg_wr) begin
      nxt_cfg = WR.cfg_wdata;
    end
    if (sticky_wr) begin
      nxt_sticky = WR.sticky_wdata;
    end
    if (cfg_clr) begin
      nxt_cfg = PRC_CFG_RST;
    end
    if (sticky_clr) begin
      nxt_sticky = PRC_STICKY_RST;
    end
  end

  always_ff @(posedge CLK) begin
    cfg_ff <= nxt_cfg;
  end

  always_ff @(posedge CLK) begin
    sticky_ff <= nxt_sticky;
  end

  // pins follow the function only in run state with both resets clear
  // suspend only shields registers; the pins float just the same
  assign pin_drive = ~any_rst & (state_ff == PRC_ST_RUN);

  // outputs float
  // a released pad has its data parked low so nothing toggles behind it
  for (genvar i = 0; i < PRC_NUM_OUT; i++) begin : g_pin
    // one slice per pad
    assign nxt_pins.data[i] = pin_drive ? FUNC_OUT[i] : PRC_OUT_RST[i];
    assign nxt_pins.oe[i] = pin_drive ? FUNC_OE[i] : PRC_OUT_RST[i];
  end

  // registered so the pads never see a glitch from the decode
  always_ff @(posedge CLK) begin
    pins_ff <= nxt_pins;
  end

  assign FUNC_ENABLE = (state_ff == PRC_ST_RUN);
  assign CFG_Q = cfg_ff;
  assign STICKY_Q = sticky_ff;
  assign PINS = pins_ff;
endmodule : prc_reset_ctrl

// >>> bench/prc_host.sv
// host platform reset drivers
`timescale 1ns/1ps
module prc_host (
  input wire logic clk,
  input wire logic boot,
  input wire logic breq,
  output logic global_reset_in,
  output logic pci_bus_reset_in
);
  always_ff @(posedge clk) begin
    global_reset_in <= boot;
    pci_bus_reset_in <= breq;
  end
endmodule : prc_host

// >>> bench/prc_chk_sva.sv
// port assertions for the reset control block
`timescale 1ns/1ps
module prc_chk
  import prc_pkg::*;
(
  input wire logic CLK, RST, GLOBAL_RESET_IN, PCI_BUS_RESET_IN, SUSPEND_IN, FUNC_ENABLE,
  input wire prc_wr_s WR,
  input wire logic [7:0] FUNC_OUT, FUNC_OE, CFG_Q, STICKY_Q,
  input wire prc_pins_s PINS
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  glb_float_a: assert property (GLOBAL_RESET_IN [*4] |-> {PINS, FUNC_ENABLE} == 0)
    else $error("global float");
  bus_float_a: assert property (PCI_BUS_RESET_IN [*4] |-> {PINS.oe, FUNC_ENABLE} == 0)
    else $error("bus float");
  bus_clear_a: assert property ((PCI_BUS_RESET_IN && !SUSPEND_IN) [*4] |-> CFG_Q == 0)
    else $error("bus clear");
  sticky_keep_a: assert property (!GLOBAL_RESET_IN [*5] |-> $stable(STICKY_Q) ||
    $past(FUNC_ENABLE && WR.sticky_we)) else $error("sticky lost");
  susp_keep_a: assert property ((SUSPEND_IN && !FUNC_ENABLE) [*5] |=>
    $stable({CFG_Q, STICKY_Q})) else $error("suspend lost");
  pin_follow_a: assert property (FUNC_ENABLE [*2] |-> PINS == $past({FUNC_OUT, FUNC_OE}))
    else $error("pins wrong");
endmodule : prc_chk
bind prc_reset_ctrl prc_chk u_chk (.*);

// >>> bench/tb_top.sv
// bench for the reset control block
`timescale 1ns/1ps
module tb_top;
  import prc_pkg::*;
  logic CLK = 0, RST = 1, boot = 1, breq = 0, SUSPEND_IN = 0, g, p, FUNC_ENABLE;
  prc_wr_s WR = '0;
  logic [7:0] FO = 8'h5a, FE = 8'hff, CFG_Q, STICKY_Q;
  prc_pins_s PINS;
  int n_fail = 0, n_checks = 0;
  wire [32:0] st = {FUNC_ENABLE, CFG_Q, STICKY_Q, PINS};
  always #20 CLK = ~CLK;
  prc_host host (.clk(CLK), .boot, .breq, .global_reset_in(g), .pci_bus_reset_in(p));
  prc_reset_ctrl uut (.CLK, .RST, .GLOBAL_RESET_IN(g), .PCI_BUS_RESET_IN(p), .SUSPEND_IN,
    .WR, .FUNC_OUT(FO), .FUNC_OE(FE), .FUNC_ENABLE, .CFG_Q, .STICKY_Q, .PINS);
  task automatic chk(input logic [32:0] s, e);
    n_checks++;
    if (s !== e) begin
      n_fail++;
      $display("FAIL %0t got %h want %h", $time, s, e);
    end
  endtask : chk
  // sticky data is the inverse of the cfg data, so the two never alias
  // reset pins settle through the synchroniser before any write is offered
  task automatic go(input logic b, r, s, w, input logic [7:0] d);
    @(posedge CLK) begin
      boot <= b;
      breq <= r;
      SUSPEND_IN <= s;
    end
    repeat (6) @(posedge CLK);
    WR <= '{w, d, w, ~d};
    @(posedge CLK) WR <= '0;
    repeat (2) @(posedge CLK);
    #1;
  endtask : go
  task automatic t_write;
    go(0, 0, 0, 1, 8'ha5);
    chk(st, 33'h1a55a5aff);
    $display("write end");
  endtask : t_write
  task automatic t_bus;
    go(0, 1, 0, 0, 8'h00);
    go(0, 1, 0, 1, 8'hff);
    chk(st, 33'h0005a0000);
    go(0, 0, 0, 0, 8'h00);
    chk(st, 33'h1005a5aff);
    $display("bus end");
  endtask : t_bus
  task automatic t_susp;
    go(0, 0, 1, 1, 8'h66);
    go(1, 1, 1, 0, 8'h00);
    chk(st, 33'h066990000);
    go(0, 0, 1, 0, 8'h00);
    go(0, 0, 0, 0, 8'h00);
    chk(st, 33'h166995aff);
    $display("suspend end");
  endtask : t_susp
  task automatic t_glob;
    go(1, 0, 0, 0, 8'h00);
    chk(st, 33'h000000000);
    $display("global end");
  endtask : t_glob
  task automatic report_and_stop;
    $display("checks %0d fails %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop
  initial begin
    #20000;
    n_fail++;
    report_and_stop;
  end
  initial begin
    repeat (16) @(posedge CLK);
    RST <= 0;
    t_write;
    t_bus;
    t_susp;
    t_glob;
    report_and_stop;
  end
endmodule : tb_top
